/* File: rtl/rxstat_bank.sv */
// Receive frame statistics counter bank with register port
// Notes on behaviour
// - FCS counter counts whole-octet frames failing the FCS check.
// - Frames also too long or runt are not FCS-counted.
// - FCS counter is 16 bits, wraps to zero after all ones.
// - FCS counter reaching 0xC000 raises the threshold event.
// - FCS counts only with global enable set and its mask clear.
// - Overrun counter counts filtered frames partly lost to FIFO overrun.
// - Frames dropped because FIFO was full at start are excluded.
// - Only overruns visible to the host are counted.
// - Overrun counter is 16 bits, wraps to zero after all ones.
// - Overrun counter reaching 0xC000 raises the threshold event.
// - Overrun counts only with global enable set and its mask clear.
// - Good counter counts each error-free completed frame once.
// - Too long, FCS, length, alignment or overrun frames are not good.
// - Good counter is 32 bits, wraps to zero after all ones.
// - Good counter reaching 0xC0000000 raises the threshold event.
// - Good counts only with global enable set and its mask clear.
`timescale 1ns/1ps
`default_nettype none
module rxstat_bank (
  input wire logic mclk, // 125 MHz clock
  input wire logic resetn, // Async reset, active low
  input wire logic frame_done, // One-cycle pulse at end of each received frame
  input wire logic fcs_bad, // Frame failed FCS check
  input wire logic octet_aligned, // Frame was a whole number of octets
  input wire logic too_long, // Frame too long
  input wire logic runt, // Frame too short
  input wire logic length_err, // Length field error
  input wire logic align_err, // Alignment error
  input wire logic addr_match, // Frame passed address filtering
  input wire logic overrun, // Frame partly lost to FIFO overrun
  input wire logic full_at_start, // FIFO full when frame began, frame ignored
  input wire logic stats_global_enable, // Global statistics enable
  input wire logic [2:0] stats_counter_mask, // Per-counter mask, 1 stops counting
  input wire logic reg_wr, // Register write strobe
  input wire logic reg_rd, // Register read strobe
  input wire logic [7:0] reg_addr, // Register byte offset
  input wire logic [31:0] reg_wdata, // Write data
  output logic [31:0] reg_rdata, // Read data, registered
  output logic stats_threshold_event // Pulse to set the interrupt flag
);
  logic [15:0] fcs_val;
  logic [15:0] ovr_val;
  logic [31:0] good_val;
  logic fcs_hit;
  logic ovr_hit;
  logic good_hit;
  logic fcs_cnt;
  logic ovr_cnt;
  logic good_cnt;
  logic wr_fcs;
  logic wr_ovr;
  logic wr_good;
  logic fcs_frame;
  logic ovr_frame;
  logic good_frame;
  logic fcs_on;
  logic ovr_on;
  logic good_on;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic evt_reg;
  logic evt_next;

  function automatic logic stat_on(input logic global_en, input logic [2:0] mask, input int bit_idx);
    stat_on = global_en && !mask[bit_idx];
  endfunction : stat_on

  always_comb begin
    fcs_on = stat_on(stats_global_enable, stats_counter_mask, rxstat_pkg::MASK_FCS_BIT);
    ovr_on = stat_on(stats_global_enable, stats_counter_mask, rxstat_pkg::MASK_OVR_BIT);
    good_on = stat_on(stats_global_enable, stats_counter_mask, rxstat_pkg::MASK_GOOD_BIT);

    // Too-long and runt frames take precedence, so such a frame never lands in the FCS count
    fcs_frame = fcs_bad && octet_aligned
      && !too_long && !runt;
    // Host-visible overrun only: the frame was partly stored, not ignored outright
    ovr_frame = addr_match && overrun
      && !full_at_start;
    good_frame = !fcs_bad && !too_long && !runt && !length_err
      && !align_err && !overrun && !full_at_start;

    fcs_cnt = frame_done && fcs_frame && fcs_on;
    ovr_cnt = frame_done && ovr_frame && ovr_on;
    good_cnt = frame_done && good_frame && good_on;
    wr_fcs = reg_wr && (reg_addr == rxstat_pkg::FCS_ERR_OFFSET);
    wr_ovr = reg_wr && (reg_addr == rxstat_pkg::OVR_LOST_OFFSET);
    wr_good = reg_wr && (reg_addr == rxstat_pkg::GOOD_RX_OFFSET);
  end

  rxstat_counter #(
    .WIDTH(16),
    .THRESH(rxstat_pkg::THRESH16),
    .RESET_VAL(rxstat_pkg::FCS_ERR_RESET)
  ) u_fcs (
    .mclk(mclk),
    .resetn(resetn),
    .count_en(fcs_cnt),
    .load(wr_fcs),
    .load_data(reg_wdata[15:0]),
    .value(fcs_val),
    .hit(fcs_hit)
  );

  rxstat_counter #(
    .WIDTH(16),
    .THRESH(rxstat_pkg::THRESH16),
    .RESET_VAL(rxstat_pkg::OVR_LOST_RESET)
  ) u_ovr (
    .mclk(mclk),
    .resetn(resetn),
    .count_en(ovr_cnt),
    .load(wr_ovr),
    .load_data(reg_wdata[15:0]),
    .value(ovr_val),
    .hit(ovr_hit)
  );

  rxstat_counter #(
    .WIDTH(32),
    .THRESH(rxstat_pkg::THRESH32),
    .RESET_VAL(rxstat_pkg::GOOD_RX_RESET)
  ) u_good (
    .mclk(mclk),
    .resetn(resetn),
    .count_en(good_cnt),
    .load(wr_good),
    .load_data(reg_wdata),
    .value(good_val),
    .hit(good_hit)
  );

  always_comb begin
    rdata_next = rdata_reg;
    evt_next = fcs_hit || ovr_hit || good_hit;
    if (reg_rd) begin
      unique case (reg_addr)
        rxstat_pkg::FCS_ERR_OFFSET: begin
          rdata_next = {16'h0000, fcs_val};
        end
        rxstat_pkg::OVR_LOST_OFFSET: begin
          rdata_next = {16'h0000, ovr_val};
        end
        rxstat_pkg::GOOD_RX_OFFSET: begin
          rdata_next = good_val;
        end
        // Unmapped offsets read as zero so software never mistakes them for a count
        default: begin
          rdata_next = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= 32'h00000000;
      evt_reg <= 1'b0;
    end else begin
      rdata_reg <= rdata_next;
      evt_reg <= evt_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign stats_threshold_event = evt_reg;

  // Checks sample on the rising edge and stand down while reset is low
  fcs_count_a: assert property (@(posedge mclk) disable iff (!resetn)
    (fcs_cnt && !wr_fcs) |=> fcs_val == $past(fcs_val) + 16'h0001)
    else $error("FCS counter did not step");

  fcs_unaligned_a: assert property (@(posedge mclk) disable iff (!resetn)
    (frame_done && !octet_aligned && !wr_fcs) |=> $stable(fcs_val))
    else $error("FCS counter moved on a frame with stray bits");

  fcs_qualify_a: assert property (@(posedge mclk) disable iff (!resetn)
    (frame_done && (too_long || runt) && !wr_fcs) |=> $stable(fcs_val))
    else $error("FCS counter moved on a long or runt frame");

  fcs_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
    (fcs_cnt && !wr_fcs && fcs_val == 16'hFFFF) |=> fcs_val == 16'h0000)
    else $error("FCS counter did not wrap");

  fcs_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && reg_addr == rxstat_pkg::FCS_ERR_OFFSET) |=> reg_rdata == {16'h0000, $past(fcs_val)})
    else $error("FCS counter read back wrongly");

  fcs_event_a: assert property (@(posedge mclk) disable iff (!resetn)
    (fcs_cnt && !wr_fcs && fcs_val == 16'hBFFF) |=> ##1 stats_threshold_event)
    else $error("FCS threshold event missing");

  fcs_enable_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!stats_global_enable && !wr_fcs) |=> $stable(fcs_val))
    else $error("FCS counter moved while disabled");

  fcs_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
    (stats_counter_mask[rxstat_pkg::MASK_FCS_BIT] && !wr_fcs) |=> $stable(fcs_val))
    else $error("FCS counter moved while masked");

  ovr_count_a: assert property (@(posedge mclk) disable iff (!resetn)
    (ovr_cnt && !wr_ovr) |=> ovr_val == $past(ovr_val) + 16'h0001)
    else $error("Overrun counter did not step");

  ovr_excl_a: assert property (@(posedge mclk) disable iff (!resetn)
    (full_at_start && !wr_ovr) |=> $stable(ovr_val))
    else $error("Ignored frame counted as overrun");

  ovr_match_a: assert property (@(posedge mclk) disable iff (!resetn)
    (frame_done && !addr_match && !wr_ovr) |=> $stable(ovr_val))
    else $error("Filtered-out frame counted as overrun");

  ovr_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
    (ovr_cnt && !wr_ovr && ovr_val == 16'hFFFF) |=> ovr_val == 16'h0000)
    else $error("Overrun counter did not wrap");

  ovr_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && reg_addr == rxstat_pkg::OVR_LOST_OFFSET) |=> reg_rdata == {16'h0000, $past(ovr_val)})
    else $error("Overrun counter read back wrongly");

  ovr_event_a: assert property (@(posedge mclk) disable iff (!resetn)
    (ovr_cnt && !wr_ovr && ovr_val == 16'hBFFF) |=> ##1 stats_threshold_event)
    else $error("Overrun threshold event missing");

  ovr_enable_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!stats_global_enable && !wr_ovr) |=> $stable(ovr_val))
    else $error("Overrun counter moved while disabled");

  ovr_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
    (stats_counter_mask[rxstat_pkg::MASK_OVR_BIT] && !wr_ovr) |=> $stable(ovr_val))
    else $error("Overrun counter moved while masked");

  good_count_a: assert property (@(posedge mclk) disable iff (!resetn)
    (good_cnt && !wr_good) |=> good_val == $past(good_val) + 32'h00000001)
    else $error("Good counter did not step");

  good_excl_a: assert property (@(posedge mclk) disable iff (!resetn)
    (frame_done && (fcs_bad || overrun) && !wr_good) |=> $stable(good_val))
    else $error("Errored frame counted as good");

  good_length_a: assert property (@(posedge mclk) disable iff (!resetn)
    (frame_done && (too_long || length_err || align_err) && !wr_good) |=> $stable(good_val))
    else $error("Length or alignment error counted as good");

  good_full_a: assert property (@(posedge mclk) disable iff (!resetn)
    (frame_done && full_at_start && !wr_good) |=> $stable(good_val))
    else $error("Frame lost to a full FIFO counted as good");

  good_wrap_a: assert property (@(posedge mclk) disable iff (!resetn)
    (good_cnt && !wr_good && good_val == 32'hFFFFFFFF) |=> good_val == 32'h00000000)
    else $error("Good counter did not wrap");

  good_read_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && reg_addr == rxstat_pkg::GOOD_RX_OFFSET) |=> reg_rdata == $past(good_val))
    else $error("Good counter read back wrongly");

  good_event_a: assert property (@(posedge mclk) disable iff (!resetn)
    (good_cnt && !wr_good && good_val == 32'hBFFFFFFF) |=> ##1 stats_threshold_event)
    else $error("Good threshold event missing");

  good_enable_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!stats_global_enable && !wr_good) |=> $stable(good_val))
    else $error("Good counter moved while disabled");

  good_mask_a: assert property (@(posedge mclk) disable iff (!resetn)
    (stats_counter_mask[rxstat_pkg::MASK_GOOD_BIT] && !wr_good) |=> $stable(good_val))
    else $error("Good counter moved while masked");

  sw_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_good |=> good_val == $past(reg_wdata))
    else $error("Software write did not load counter");

  fcs_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_fcs |=> fcs_val == $past(reg_wdata[15:0]))
    else $error("Software write did not load FCS counter");

  ovr_load_a: assert property (@(posedge mclk) disable iff (!resetn)
    wr_ovr |=> ovr_val == $past(reg_wdata[15:0]))
    else $error("Software write did not load overrun counter");

  idle_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (!frame_done && !reg_wr)
      |=> ($stable(fcs_val) && $stable(ovr_val) && $stable(good_val)))
    else $error("Counter moved with no frame and no write");

  stray_write_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_wr && !wr_fcs && !wr_ovr && !wr_good && !frame_done)
      |=> ($stable(fcs_val) && $stable(ovr_val) && $stable(good_val)))
    else $error("Unmapped write moved a counter");

  event_cause_a: assert property (@(posedge mclk) disable iff (!resetn)
    stats_threshold_event |-> ($past(fcs_val) == rxstat_pkg::THRESH16 || $past(ovr_val) == rxstat_pkg::THRESH16
      || $past(good_val) == rxstat_pkg::THRESH32))
    else $error("Threshold event without a counter at threshold");

  read_unmapped_a: assert property (@(posedge mclk) disable iff (!resetn)
    (reg_rd && reg_addr != rxstat_pkg::FCS_ERR_OFFSET && reg_addr != rxstat_pkg::OVR_LOST_OFFSET
      && reg_addr != rxstat_pkg::GOOD_RX_OFFSET) |=> reg_rdata == 32'h00000000)
    else $error("Unmapped read returned nonzero data");

  read_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    !reg_rd |=> $stable(reg_rdata))
    else $error("Read data changed without a read");
endmodule : rxstat_bank
`default_nettype wire

/* File: rtl/rxstat_pkg.sv */
// Constants for the receive frame statistics counter bank
package rxstat_pkg;
  localparam logic [7:0] GOOD_RX_OFFSET = 8'hB4;
  localparam logic [7:0] FCS_ERR_OFFSET = 8'hB8;
  localparam logic [7:0] OVR_LOST_OFFSET = 8'hBC;
  localparam logic [31:0] GOOD_RX_RESET = 32'h00000000;
  localparam logic [15:0] FCS_ERR_RESET = 16'h0000;
  localparam logic [15:0] OVR_LOST_RESET = 16'h0000;
  localparam logic [15:0] THRESH16 = 16'hC000;
  localparam logic [31:0] THRESH32 = 32'hC0000000;
  localparam int MASK_FCS_BIT = 0;
  localparam int MASK_OVR_BIT = 1;
  localparam int MASK_GOOD_BIT = 2;
  localparam int MASK_WIDTH = 3;
endpackage : rxstat_pkg

/* File: rtl/rxstat_counter.sv */
// One wrapping statistics counter with software load and threshold event
`timescale 1ns/1ps
`default_nettype none
module rxstat_counter #(
  parameter int WIDTH = 16,
  parameter logic [WIDTH-1:0] THRESH = '0,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire logic mclk, // Clock
  input wire logic resetn, // Async reset, active low
  input wire logic count_en, // Qualified count event
  input wire logic load, // Software write strobe
  input wire logic [WIDTH-1:0] load_data, // Value to load
  output logic [WIDTH-1:0] value, // Counter value
  output logic hit // Pulse when counter reaches threshold
);
  logic [WIDTH-1:0] cnt_reg;
  logic [WIDTH-1:0] cnt_next;
  logic hit_reg;
  logic hit_next;

  always_comb begin
    cnt_next = cnt_reg;
    hit_next = 1'b0;
    if (load) begin
      // Software write wins over a same-cycle count event
      cnt_next = load_data;
    end else if (count_en) begin
      cnt_next = cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1}; // Wraps to zero from all ones
      hit_next = (cnt_next == THRESH);
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= RESET_VAL;
      hit_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      hit_reg <= hit_next;
    end
  end

  assign value = cnt_reg;
  assign hit = hit_reg;
endmodule : rxstat_counter
`default_nettype wire

/* File: sim/rxstat_rx_model.sv */
// Receive status source standing in for the MAC frame and FIFO logic
`timescale 1ns/1ps
`default_nettype none
module rxstat_rx_model (
  input wire logic mclk, // Clock
  input wire logic go, // Issue one end of frame
  input wire logic [8:0] fl, // Status flags for that frame
  output logic frame_done, // End-of-frame pulse
  output logic [8:0] st // Status flags, scrambled between frames
);
  initial begin
    frame_done = 1'b0;
    st = 9'h000;
  end
  // Flags mean nothing without the pulse, so they toggle to catch a bank that samples them late
  always @(posedge mclk) begin
    frame_done <= go;
    st <= go ? fl : ~st;
  end
endmodule : rxstat_rx_model
`default_nettype wire

/* File: sim/rxstat_bank_test.sv */
// Self-checking bench for the receive statistics counter bank
`timescale 1ns/1ps
`default_nettype none
module rxstat_bank_test;
  localparam logic [7:0] A_G = rxstat_pkg::GOOD_RX_OFFSET;
  localparam logic [7:0] A_F = rxstat_pkg::FCS_ERR_OFFSET;
  localparam logic [7:0] A_O = rxstat_pkg::OVR_LOST_OFFSET;
  // Flag order: fcs, aligned, long, runt, length, align, match, overrun, full at start
  localparam logic [8:0] FR_GOOD = 9'h080;
  localparam logic [8:0] FR_FCS = 9'h180;
  localparam logic [8:0] FR_OVR = 9'h086;
  logic mclk, resetn, go, rd, wr, en, done, ev;
  logic [8:0] fl, st;
  logic [2:0] mask;
  logic [7:0] addr;
  logic [31:0] wd, rdat, ef, eo, eg;
  int err_total, tests_run, ev_cnt;
  // Row: frame flags, then increments expected of fcs, overrun and good counters
  logic [11:0] rows [11] = '{12'h401, 12'hC04, 12'hE00, 12'hD00, 12'h800, 12'h432,
                             12'h438, 12'h410, 12'h480, 12'h440, 12'h408};
  rxstat_rx_model u_mac (.mclk(mclk), .go(go), .fl(fl), .frame_done(done), .st(st));
  rxstat_bank u_dut (.mclk(mclk), .resetn(resetn), .frame_done(done), .fcs_bad(st[8]),
    .octet_aligned(st[7]), .too_long(st[6]), .runt(st[5]), .length_err(st[4]), .align_err(st[3]),
    .addr_match(st[2]), .overrun(st[1]), .full_at_start(st[0]), .stats_global_enable(en),
    .stats_counter_mask(mask), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rdat), .stats_threshold_event(ev));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // A pulse that stands two cycles counts twice and shows up in the totals
  always @(posedge mclk) if (ev === 1'b1) ev_cnt++;
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk) rd <= 1'b1;
    addr <= a;
    @(posedge mclk) rd <= 1'b0;
    #1 chk(rdat, e);
  endtask : rdc
  task wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge mclk) wr <= 1'b0;
  endtask : wrr
  task send(input logic [8:0] f);
    @(posedge mclk) go <= 1'b1;
    fl <= f;
    @(posedge mclk) go <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask : send
  task rd3;
    rdc(A_G, eg);
    rdc(A_F, ef);
    rdc(A_O, eo);
  endtask : rd3
  task edge_case(input logic [7:0] a, input logic [31:0] pre, input logic [8:0] f,
                 input logic [31:0] e, input int n);
    int e0;
    wrr(a, pre);
    e0 = ev_cnt;
    send(f);
    rdc(a, e);
    chk(32'(ev_cnt - e0), 32'(n));
  endtask : edge_case
  task close_out;
    $display("errors %0d, checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out
  initial begin
    repeat (3000) @(posedge mclk);
    err_total++;
    close_out();
  end
  initial begin
    resetn = 1'b0;
    {go, rd, wr, en, fl, mask, addr, wd} = '0;
    {ef, eo, eg} = '0;
    en = 1'b1;
    repeat (3) @(posedge mclk);
    resetn <= 1'b1;
    rd3();
    rdc(8'h00, 32'h00000000);
    foreach (rows[i]) begin
      send(rows[i][11:3]);
      ef += 32'(rows[i][2]);
      eo += 32'(rows[i][1]);
      eg += 32'(rows[i][0]);
      rd3();
    end
    // Pass 3 clears the enable instead of masking
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk) mask <= (i < 3) ? 3'(3'b001 << i) : 3'b000;
      en <= (i < 3);
      send(FR_FCS);
      send(FR_OVR);
      send(FR_GOOD);
      ef += 32'(i == 1 || i == 2);
      eo += 32'(i == 0 || i == 2);
      eg += 32'(i < 2);
      rd3();
    end
    @(posedge mclk) en <= 1'b1;
    edge_case(A_F, 32'h0000BFFF, FR_FCS, 32'h0000C000, 1);
    edge_case(A_F, 32'h0000FFFF, FR_FCS, 32'h00000000, 0);
    edge_case(A_O, 32'h0000BFFF, FR_OVR, 32'h0000C000, 1);
    edge_case(A_O, 32'h0000FFFF, FR_OVR, 32'h00000000, 0);
    edge_case(A_G, 32'hBFFFFFFF, FR_GOOD, 32'hC0000000, 1);
    edge_case(A_G, 32'hFFFFFFFF, FR_GOOD, 32'h00000000, 0);
    {ef, eo, eg} = '0;
    wrr(8'h00, 32'h0000FFFF);
    rd3();
    // Mid-run reset must clear the counters and the held read data
    wrr(A_G, 32'h00000007);
    rdc(A_G, 32'h00000007);
    @(posedge mclk) resetn <= 1'b0;
    repeat (2) @(posedge mclk);
    #1 chk(rdat, 32'h00000000);
    @(posedge mclk) resetn <= 1'b1;
    rd3();
    close_out();
  end
endmodule : rxstat_bank_test
`default_nettype wire
